// File: logic/sst_exec.sv
`timescale 1ns/100ps
`include "sst_map.svh"
module sst_exec
    import sst_pkg::*;
#(
    parameter int DM_AW = 8
)
(
    input  wire logic        hclk,          // core clock, 20 MHz
    input  wire logic        hresetn,       // async reset, active low
    input  wire logic        hsel,          // slave select
    input  wire logic [31:0] haddr,         // byte address
    input  wire logic [1:0]  htrans,        // transfer type
    input  wire logic        hwrite,        // write when high
    input  wire logic [2:0]  hsize,         // transfer size
    input  wire logic [31:0] hwdata,        // write data
    input  wire logic        hready,        // bus ready in
    output logic             hreadyout,     // slave ready out
    output logic             hresp,         // always okay
    output logic      [31:0] hrdata,        // read data
    input  wire logic [7:0]  cur_page,      // current program page from sequencer
    output logic      [15:0] pm_addr,       // program memory word address
    output logic             pm_rd,         // program memory read strobe
    input  wire logic [15:0] pm_rdata,      // program word, one cycle after strobe
    output logic             busy,          // instruction in progress
    output logic             skip_pulse,    // next instruction is skipped
    output logic             dummy_cycle,   // dummy instruction slot
    output logic             z_flag         // zero flag
);

    sst_state_t  st_r;                   // execution state
    sst_cmd_t    cmd_r;                  // latched command word
    sst_pmreq_t  pmq_r;                  // program memory request
    logic [7:0]  acc_r, tplo_r, tphi_r, thb_r, daddr_r, waddr_r;
    logic [7:0]  dm_rdata, dm_addr, dm_wdata, xor_src, xor_res, nib_swap;
    logic        z_r, last_skip_r, wr_valid_r, rd_dd_r, dm_we, acc_ph;
    logic        idle, exec, cmd_go, is_table, skip_c, is_xor;
    logic [15:0] tb_addr;
    logic [31:0] rdata_r, rd_mux;

    // bus handshake: never waits, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign acc_ph    = hsel && htrans[1] && hready;

    // state decode
    assign idle        = (st_r == S_IDLE);
    assign exec        = (st_r == S_EX);
    assign busy        = !idle;
    assign dummy_cycle = (st_r == S_DUMMY);
    assign z_flag      = z_r;
    assign pm_addr     = pmq_r.addr;
    assign pm_rd       = pmq_r.rd;
    assign cmd_go      = wr_valid_r && (waddr_r == `SST_OFF_CMD) && idle;

    // operand paths
    assign nib_swap = {dm_rdata[3:0], dm_rdata[7:4]};
    assign xor_src  = (cmd_r.opcode == `SST_OP_XORI) ? cmd_r.imm : dm_rdata;
    assign xor_res  = acc_r ^ xor_src;
    assign is_xor   = cmd_r.opcode inside {`SST_OP_XORA, `SST_OP_XMEM, `SST_OP_XORI};
    assign is_table = cmd_r.opcode inside {`SST_OP_TBG, `SST_OP_TBC, `SST_OP_TBF};

    // skip decision, valid in the execute cycle
    always_comb
    begin
        case (cmd_r.opcode)
            `SST_OP_SKZ:   skip_c = exec && (dm_rdata == `SST_ZERO_BYTE);
            `SST_OP_CPSKZ: skip_c = exec && (dm_rdata == `SST_ZERO_BYTE);
            `SST_OP_SKBZ:  skip_c = exec && !dm_rdata[cmd_r.bitsel];
            default:       skip_c = 1'b0;
        endcase
    end
    assign skip_pulse = skip_c;

    // table address by page kind
    always_comb
    begin
        case (cmd_r.opcode)
            `SST_OP_TBG: tb_addr = {tphi_r, tplo_r};
            `SST_OP_TBC: tb_addr = {cur_page, tplo_r};
            `SST_OP_TBF: tb_addr = {`SST_LAST_PAGE, tplo_r};
            default:     tb_addr = {tphi_r, tplo_r};
        endcase
    end

    // data memory port sharing: sequence owns it while busy
    assign dm_addr  = busy ? cmd_r.addr
                    : (wr_valid_r && (waddr_r == `SST_OFF_DADDR)) ? hwdata[7:0] : daddr_r;
    // write sources: xor result, table low byte, or a bus write while idle
    assign dm_we    = (exec && (cmd_r.opcode == `SST_OP_XMEM))
                      || (st_r == S_TB)
                      || (idle && wr_valid_r && (waddr_r == `SST_OFF_DDATA));
    assign dm_wdata = exec ? xor_res : ((st_r == S_TB) ? pm_rdata[7:0] : hwdata[7:0]);

    sst_dmem #(.DW(8), .AW(DM_AW)) u_dmem (
        .clk     (hclk),
        .rst_n   (hresetn),
        .addr    (dm_addr),
        .we      (dm_we),
        .wdata   (dm_wdata),
        .rdata_r (dm_rdata)
    );

    // bus address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_valid_r <= 1'b0;
            waddr_r    <= 8'h00;
            rd_dd_r    <= 1'b0;
        end
        else
        begin
            wr_valid_r <= acc_ph && hwrite;
            waddr_r    <= haddr[7:0];
            rd_dd_r    <= acc_ph && !hwrite && (haddr[7:0] == `SST_OFF_DDATA);
        end
    end

    // read data mux, unmapped reads as zero
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            `SST_OFF_CMD:    rd_mux = {8'h00, cmd_r};
            `SST_OFF_ACC:    rd_mux = {24'h00_0000, acc_r};
            `SST_OFF_STATUS:
            begin
                rd_mux[`SST_ST_Z]    = z_r;
                rd_mux[`SST_ST_BUSY] = busy;
                rd_mux[`SST_ST_SKIP] = last_skip_r;
            end
            `SST_OFF_TPLO:   rd_mux = {24'h00_0000, tplo_r};
            `SST_OFF_TPHI:   rd_mux = {24'h00_0000, tphi_r};
            `SST_OFF_THB:    rd_mux = {24'h00_0000, thb_r};
            `SST_OFF_DADDR:  rd_mux = {24'h00_0000, daddr_r};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // read data register, data memory reads come from its own register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rdata_r <= 32'h0000_0000;
        end
        else if (acc_ph && !hwrite)
        begin
            rdata_r <= rd_mux;
        end
    end
    assign hrdata = rd_dd_r ? {24'h00_0000, dm_rdata} : rdata_r;

    // pointer and address registers, frozen while busy
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tplo_r  <= `SST_TBL_RST;
            tphi_r  <= `SST_TBL_RST;
            daddr_r <= `SST_TBL_RST;
        end
        else if (wr_valid_r && idle)
        begin
            if (waddr_r == `SST_OFF_TPLO)
                tplo_r <= hwdata[7:0];
            if (waddr_r == `SST_OFF_TPHI)
                tphi_r <= hwdata[7:0];
            if (waddr_r == `SST_OFF_DADDR)
                daddr_r <= hwdata[7:0];
        end
    end

    // command register, taken only when idle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cmd_r <= '0;
        end
        else if (cmd_go)
        begin
            cmd_r <= hwdata[23:0];
        end
    end

    // execution sequence
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_r <= S_IDLE;
        end
        else
        begin
            case (st_r)
                S_IDLE:
                    if (cmd_go)
                        st_r <= S_RD;
                S_RD:
                    st_r <= S_EX;
                S_EX:
                    if (is_table)
                        st_r <= S_TB;
                    else if (skip_c)
                        st_r <= S_DUMMY;
                    else
                        st_r <= S_IDLE;
                S_TB:
                    st_r <= S_IDLE;
                S_DUMMY:
                    st_r <= S_IDLE;
                default:
                    st_r <= S_IDLE;
            endcase
        end
    end

    // program memory request, strobe during execute
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pmq_r <= '0;
        end
        else
        begin
            pmq_r.rd <= (st_r == S_RD) && is_table;
            if ((st_r == S_RD) && is_table)
                pmq_r.addr <= tb_addr;
        end
    end

    // table high byte latch
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            thb_r <= `SST_TBL_RST;
        end
        else if (st_r == S_TB)
        begin
            thb_r <= pm_rdata[15:8];
        end
    end

    // accumulator
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            acc_r <= `SST_ACC_RST;
        end
        else if (exec)
        begin
            case (cmd_r.opcode)
                `SST_OP_NIBX:  acc_r <= nib_swap;
                `SST_OP_CPSKZ: acc_r <= dm_rdata;
                `SST_OP_XORA:  acc_r <= xor_res;
                `SST_OP_XORI:  acc_r <= xor_res;
                default:       acc_r <= acc_r;
            endcase
        end
        else if (idle && wr_valid_r && (waddr_r == `SST_OFF_ACC))
        begin
            acc_r <= hwdata[7:0];
        end
    end

    // zero flag and last skip status
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            z_r         <= 1'b0;
            last_skip_r <= 1'b0;
        end
        else if (exec)
        begin
            if (is_xor)
                z_r <= (xor_res == `SST_ZERO_BYTE);
            last_skip_r <= skip_c;
        end
        else if (idle && wr_valid_r && (waddr_r == `SST_OFF_STATUS))
        begin
            z_r <= hwdata[`SST_ST_Z];
        end
    end

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_nibx;
        exec && (cmd_r.opcode == `SST_OP_NIBX) |=> (acc_r == $past(nib_swap)) && $stable(z_r);
    endproperty
    a_nibx: assert property (p_nibx) else $error("nibble exchange result wrong");
    property p_skz;
        exec && (cmd_r.opcode == `SST_OP_SKZ) |-> skip_pulse == (dm_rdata == `SST_ZERO_BYTE);
    endproperty
    a_skz: assert property (p_skz) else $error("byte zero test skip wrong");
    property p_dummy;
        skip_pulse |=> dummy_cycle ##1 (!dummy_cycle && idle);
    endproperty
    a_dummy: assert property (p_dummy) else $error("skip without one dummy cycle");
    property p_cpskz;
        exec && (cmd_r.opcode == `SST_OP_CPSKZ) |=> (acc_r == $past(dm_rdata)) && (dummy_cycle == $past(skip_pulse));
    endproperty
    a_cpskz: assert property (p_cpskz) else $error("copy and test wrong");
    property p_skbz;
        exec && (cmd_r.opcode == `SST_OP_SKBZ) |-> skip_pulse == !dm_rdata[cmd_r.bitsel];
    endproperty
    a_skbz: assert property (p_skbz) else $error("bit test skip wrong");
    property p_tbg;
        exec && (cmd_r.opcode == `SST_OP_TBG) |-> pm_rd && (pm_addr == {tphi_r, tplo_r})
            ##1 dm_we && (dm_wdata == pm_rdata[7:0]) ##1 (thb_r == $past(pm_rdata[15:8]));
    endproperty
    a_tbg: assert property (p_tbg) else $error("given page table fetch wrong");
    property p_tbc;
        (st_r == S_RD) && (cmd_r.opcode == `SST_OP_TBC) |=> pm_rd && (pm_addr == {$past(cur_page), tplo_r});
    endproperty
    a_tbc: assert property (p_tbc) else $error("current page address wrong");
    property p_tbf;
        exec && (cmd_r.opcode == `SST_OP_TBF) |-> pm_rd && (pm_addr == {`SST_LAST_PAGE, tplo_r})
            ##1 (st_r == S_TB) ##1 idle && $stable(z_r);
    endproperty
    a_tbf: assert property (p_tbf) else $error("final page table fetch wrong");
    property p_xora;
        exec && (cmd_r.opcode == `SST_OP_XORA) |=> (acc_r == $past(xor_res)) && (z_r == (acc_r == `SST_ZERO_BYTE));
    endproperty
    a_xora: assert property (p_xora) else $error("xor to accumulator wrong");
    property p_exclusive_or_into_memory;
        exec && (cmd_r.opcode == `SST_OP_XMEM) |-> dm_we && (dm_wdata == (acc_r ^ dm_rdata)) ##1 $stable(acc_r);
    endproperty
    a_exclusive_or_into_memory: assert property (p_exclusive_or_into_memory) else $error("xor into memory wrong");
    property p_xori;
        exec && (cmd_r.opcode == `SST_OP_XORI) |=> (acc_r == ($past(acc_r) ^ $past(cmd_r.imm))) && idle;
    endproperty
    a_xori: assert property (p_xori) else $error("immediate xor wrong");
    property p_onecycle;
        exec && !skip_pulse && !is_table |=> idle
            && (z_flag == (is_xor ? ($past(xor_res) == `SST_ZERO_BYTE) : $past(z_r)));
    endproperty
    a_onecycle: assert property (p_onecycle) else $error("non skipping op not one cycle or zero flag wrong");

endmodule

// File: logic/sst_map.svh
`ifndef SST_MAP_SVH
`define SST_MAP_SVH

// register byte offsets on the bus
`define SST_OFF_CMD    8'h00
`define SST_OFF_ACC    8'h04
`define SST_OFF_STATUS 8'h08
`define SST_OFF_TPLO   8'h0C
`define SST_OFF_TPHI   8'h10
`define SST_OFF_THB    8'h14
`define SST_OFF_DADDR  8'h18
`define SST_OFF_DDATA  8'h1C

// status register bit positions
`define SST_ST_Z    0
`define SST_ST_BUSY 1
`define SST_ST_SKIP 2

// reset values
`define SST_ACC_RST  8'h00
`define SST_TBL_RST  8'h00
`define SST_PAGE_RST 8'h00

// operation codes in the command word
`define SST_OP_NIBX  4'h0
`define SST_OP_SKZ   4'h1
`define SST_OP_CPSKZ 4'h2
`define SST_OP_SKBZ  4'h3
`define SST_OP_TBG   4'h4
`define SST_OP_TBC   4'h5
`define SST_OP_TBF   4'h6
`define SST_OP_XORA  4'h7
`define SST_OP_XMEM  4'h8
`define SST_OP_XORI  4'h9

// fixed values
`define SST_LAST_PAGE 8'hFF
`define SST_ZERO_BYTE 8'h00
`define SST_HTRANS_IDLE 2'h0

`endif

// File: logic/sst_pkg.sv
package sst_pkg;

    // command word as written to the command register
    typedef struct packed {
        logic [7:0] imm;      // immediate operand
        logic [7:0] addr;     // data memory address
        logic       rsv;      // unused
        logic [2:0] bitsel;   // bit index for the bit test
        logic [3:0] opcode;   // operation
    } sst_cmd_t;

    // execution sequence
    typedef enum logic [2:0] {
        S_IDLE,
        S_RD,
        S_EX,
        S_TB,
        S_DUMMY
    } sst_state_t;

    // program memory request
    typedef struct packed {
        logic        rd;      // read strobe
        logic [15:0] addr;    // word address
    } sst_pmreq_t;

endpackage

// File: logic/sst_dmem.sv
`timescale 1ns/100ps
// small data memory, registered read, one write port
module sst_dmem
    import sst_pkg::*;
#(
    parameter int DW = 8,
    parameter int AW = 8
)
(
    input  wire logic          clk,       // core clock
    input  wire logic          rst_n,     // async reset, active low
    input  wire logic [AW-1:0] addr,      // read and write address
    input  wire logic          we,        // write enable
    input  wire logic [DW-1:0] wdata,     // write data
    output logic      [DW-1:0] rdata_r    // registered read data
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // storage array, write on enable
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
    end

    // read register, old data on a write to the same address
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r <= '0;
        end
        else
        begin
            rdata_r <= mem[addr];
        end
    end

endmodule

// File: verification/sst_pm_model.sv
`timescale 1ns/100ps
// program memory model: word valid the cycle after the read strobe
module sst_pm_model
(
    input  wire logic        hclk,      // core clock
    input  wire logic [15:0] pm_addr,   // word address
    input  wire logic        pm_rd,     // read strobe
    output logic      [15:0] pm_rdata   // program word
);
    // word content is a fixed pattern of the address; between reads the lines toggle
    initial pm_rdata = 16'h0000;
    always @(posedge hclk)
    begin
        if (pm_rd)
            pm_rdata <= {pm_addr[15:8] ^ 8'h5A, pm_addr[7:0] ^ 8'hC3};
        else
            pm_rdata <= ~pm_rdata;
    end
endmodule

// File: verification/swap_skip_tableread_xor_exec_tb.sv
`timescale 1ns/100ps
`include "sst_map.svh"
module swap_skip_tableread_xor_exec_tb;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pm_rd;
    logic        busy, skip_pulse, dummy_cycle, z_flag;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  cur_page;
    logic [15:0] pm_addr, pm_rdata, pa;
    int          failures, cmp_count, nbusy, nskip, ndummy;
    logic [15:0] exp_pa [3];

    sst_exec dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .cur_page(cur_page), .pm_addr(pm_addr), .pm_rd(pm_rd),
        .pm_rdata(pm_rdata), .busy(busy), .skip_pulse(skip_pulse), .dummy_cycle(dummy_cycle),
        .z_flag(z_flag));
    sst_pm_model pm (.hclk(hclk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata));

    // single slave: its ready is the bus ready
    assign hready = hreadyout;

    // clock of 50 ns
    initial hclk = 1'b0;
    always #25 hclk = ~hclk;

    // count busy, skip and dummy cycles where outputs are settled
    always @(negedge hclk)
    begin
        if (busy === 1'b1) nbusy++;
        if (skip_pulse === 1'b1) nskip++;
        if (dummy_cycle === 1'b1) ndummy++;
        if (pm_rd === 1'b1) pa = pm_addr;
    end

    task complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one single transfer: address phase, then data phase
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        haddr  <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
        chk("hresp", 32'h00000000, {31'h0, hresp});
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h00000000, r);
        chk(nm, e, r);
    endtask

    task setm(input logic [7:0] m, input logic [7:0] v);
        wr(`SST_OFF_DADDR, {24'h000000, m});
        wr(`SST_OFF_DDATA, {24'h000000, v});
    endtask

    task mchk(input string nm, input logic [7:0] m, input logic [7:0] e);
        wr(`SST_OFF_DADDR, {24'h000000, m});
        rchk(nm, `SST_OFF_DDATA, {24'h000000, e});
    endtask

    // launch one instruction and wait for it under a bound
    task run(input logic [3:0] op, input logic [2:0] b, input logic [7:0] m, input logic [7:0] imm,
             input int sk, input int nb);
        int n;
        nbusy = 0;
        nskip = 0;
        ndummy = 0;
        n = 0;
        wr(`SST_OFF_CMD, {8'h00, imm, m, 1'b0, b, op});
        @(negedge hclk);
        while (busy !== 1'b0 && n < 20)
        begin
            @(negedge hclk);
            n++;
        end
        @(posedge hclk);
        chk("busy_cycles", nb, nbusy);
        chk("skip_pulse", sk, nskip);
        chk("dummy_cycle", sk, ndummy);
    endtask

    initial
    begin
        #1000000;
        failures++;
        complete_run();
    end

    initial
    begin
        failures = 0;
        cmp_count = 0;
        hresetn = 1'b0;
        hsel = 1'b1;
        hsize = 3'h2;
        htrans = `SST_HTRANS_IDLE;
        hwrite = 1'b0;
        haddr = 32'h00000000;
        hwdata = 32'h00000000;
        cur_page = 8'h56;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("acc_reset", `SST_OFF_ACC, 32'h00000000);
        rchk("unmapped", 8'h20, 32'h00000000);
        // zero flag set by software must survive non-xor instructions
        wr(`SST_OFF_STATUS, 32'h00000001);
        setm(8'h10, 8'h3C);
        run(`SST_OP_NIBX, 3'h0, 8'h10, 8'h00, 0, 2);
        rchk("acc_nibx", `SST_OFF_ACC, 32'h000000C3);
        mchk("mem_nibx", 8'h10, 8'h3C);
        setm(8'h20, 8'h00);
        setm(8'h21, 8'h80);
        setm(8'h22, 8'hA5);
        run(`SST_OP_SKZ, 3'h0, 8'h20, 8'h00, 1, 3);
        rchk("status_skip", `SST_OFF_STATUS, 32'h00000005);
        run(`SST_OP_SKZ, 3'h0, 8'h21, 8'h00, 0, 2);
        run(`SST_OP_CPSKZ, 3'h0, 8'h21, 8'h00, 0, 2);
        rchk("acc_cpskz1", `SST_OFF_ACC, 32'h00000080);
        run(`SST_OP_CPSKZ, 3'h0, 8'h20, 8'h00, 1, 3);
        rchk("acc_cpskz0", `SST_OFF_ACC, 32'h00000000);
        for (int i = 0; i < 8; i++)
            run(`SST_OP_SKBZ, i[2:0], 8'h22, 8'h00, (8'hA5 >> i) & 1 ? 0 : 1, (8'hA5 >> i) & 1 ? 2 : 3);
        // three table fetches into separate bytes
        wr(`SST_OFF_TPLO, 32'h00000034);
        wr(`SST_OFF_TPHI, 32'h00000012);
        exp_pa[0] = 16'h1234;
        exp_pa[1] = 16'h5634;
        exp_pa[2] = {`SST_LAST_PAGE, 8'h34};
        for (int i = 0; i < 3; i++)
        begin
            setm(8'h40 + i[7:0], 8'h00);
            run(`SST_OP_TBG + i[3:0], 3'h0, 8'h40 + i[7:0], 8'h00, 0, 3);
            chk("pm_addr", {16'h0000, exp_pa[i]}, {16'h0000, pa});
            mchk("table_low", 8'h40 + i[7:0], exp_pa[i][7:0] ^ 8'hC3);
            rchk("table_high", `SST_OFF_THB, {24'h000000, exp_pa[i][15:8] ^ 8'h5A});
        end
        rchk("z_kept", `SST_OFF_STATUS, 32'h00000001);
        // exclusive-or forms with zero and non-zero results
        wr(`SST_OFF_STATUS, 32'h00000000);
        wr(`SST_OFF_ACC, 32'h0000005A);
        setm(8'h23, 8'h5A);
        setm(8'h24, 8'h0F);
        run(`SST_OP_XORA, 3'h0, 8'h23, 8'h00, 0, 2);
        rchk("acc_xora", `SST_OFF_ACC, 32'h00000000);
        chk("z_xora", 32'h1, {31'h0, z_flag});
        run(`SST_OP_XORI, 3'h0, 8'h00, 8'h0F, 0, 2);
        rchk("acc_xori", `SST_OFF_ACC, 32'h0000000F);
        chk("z_xori", 32'h0, {31'h0, z_flag});
        run(`SST_OP_XMEM, 3'h0, 8'h24, 8'h00, 0, 2);
        mchk("mem_xorm0", 8'h24, 8'h00);
        chk("z_xorm0", 32'h1, {31'h0, z_flag});
        run(`SST_OP_XMEM, 3'h0, 8'h21, 8'h00, 0, 2);
        mchk("mem_xorm1", 8'h21, 8'h8F);
        rchk("acc_exclusive_or_into_memory", `SST_OFF_ACC, 32'h0000000F);
        chk("z_xorm1", 32'h0, {31'h0, z_flag});
        complete_run();
    end
endmodule
